// ### bench/msc_host_model.sv
`timescale 1ns/1ns
// ---------------------------------------------------------------
// host board controller: drives sideband pins, owns the pull-ups
// ---------------------------------------------------------------
module msc_host_model (
    // clock
    input  wire logic CLK,
    // lines the module pulls low, and the done flag read back
    input  wire logic FAULT_INTERRUPT_N_OUT,
    input  wire logic FAULT_INTERRUPT_N_OE_N,
    input  wire logic SDA_OUT,
    input  wire logic SDA_OE_N,
    input  wire logic DONE_READ,
    // host driven pins
    output logic      MODULE_SELECT_N,
    output logic      MODULE_SELECT_DRIVEN,
    output logic      MODULE_RESET_N,
    output logic      LOW_POWER_REQUEST,
    output logic      SCL_IN,
    output logic      SDA_IN,
    // resolved interrupt line and host view of status
    output logic      INT_LINE,
    output logic      STATUS_TRUSTED
);
    logic sda_low;

    // idle pins at time zero, nothing trusted yet
    initial begin
        MODULE_SELECT_N      = 1'b1;
        MODULE_SELECT_DRIVEN = 1'b0;
        MODULE_RESET_N       = 1'b1;
        LOW_POWER_REQUEST    = 1'b0;
        SCL_IN               = 1'b1;
        sda_low              = 1'b0;
        STATUS_TRUSTED       = 1'b0;
    end

    // board pull-ups: a released line reads high
    assign INT_LINE = FAULT_INTERRUPT_N_OE_N ? 1'b1 : FAULT_INTERRUPT_N_OUT;
    assign SDA_IN   = (SDA_OE_N ? 1'b1 : SDA_OUT) & ~sda_low;

    // status ignored in reset, trusted once done is read on a low interrupt
    always @(posedge CLK) begin
        if (!MODULE_RESET_N) begin
            STATUS_TRUSTED <= 1'b0;
        end else if (!INT_LINE && DONE_READ) begin
            STATUS_TRUSTED <= 1'b1;
        end
    end

    // undriven select still carries the sel_n level on purpose: the module's pull-up must win
    task automatic set_pins(input logic sel_n, input logic drv, input logic lp,
                            input logic scl, input logic sdl);
        @(posedge CLK);
        MODULE_SELECT_N      <= sel_n;
        MODULE_SELECT_DRIVEN <= drv;
        LOW_POWER_REQUEST    <= lp;
        SCL_IN               <= scl;
        sda_low              <= sdl;
    endtask : set_pins

    // hold reset low for a whole number of cycles, then release
    task automatic pulse_reset(input int cyc);
        @(posedge CLK);
        MODULE_RESET_N <= 1'b0;
        repeat (cyc) @(posedge CLK);
        MODULE_RESET_N <= 1'b1;
    endtask : pulse_reset
endmodule : msc_host_model

// ### bench/msc_sideband_tb.sv
`timescale 1ns/1ns
`define CHK(what, exp, got) begin checked++; if ((got) !== (exp)) begin miscompares++; \
    $display("Error %s expected %0h seen %0h", what, exp, got); end end
// ---------------------------------------------------------------
// sideband control bench
// ---------------------------------------------------------------
module module_sideband_control_tb;
    localparam int MINC  = 2;
    localparam int INITC = 3;
    localparam int NS    = msc_pkg::NUM_FAULT_SRC;
    logic          CLK         = 1'b0;
    logic          RST_B       = 1'b0;
    logic          ENGINE_SDA_LOW = 1'b0;
    logic [NS:0]   INT_CLEAR   = '0;
    logic [NS:1]   FAULT_EVENT = '0;
    logic          sel_n, sel_drv, scl, sda, rst_n, lp, int_line, trusted;
    logic          int_out, int_oe_n, sda_out, sda_oe_n, presence_n, bus_scl, bus_sda;
    logic [NS:0]   INT_FLAGS;
    logic          STATUS_VALID, SETTINGS_RESET, LOW_POWER_MODE;
    int            checked     = 0;
    int            miscompares = 0;
    int            mflags      = 0;
    logic          act;

    // 10 MHz clock
    always #50 CLK = ~CLK;

    msc_host_model host (.CLK(CLK), .FAULT_INTERRUPT_N_OUT(int_out),
        .FAULT_INTERRUPT_N_OE_N(int_oe_n), .SDA_OUT(sda_out), .SDA_OE_N(sda_oe_n),
        .DONE_READ(INT_FLAGS[0]), .MODULE_SELECT_N(sel_n), .MODULE_SELECT_DRIVEN(sel_drv),
        .MODULE_RESET_N(rst_n), .LOW_POWER_REQUEST(lp), .SCL_IN(scl), .SDA_IN(sda),
        .INT_LINE(int_line), .STATUS_TRUSTED(trusted));

    // short counts keep the run brief
    msc_sideband #(.RESET_MIN_CYC(MINC), .INIT_CYC(INITC), .NSRC(NS)) dut (
        .CLK(CLK), .RST_B(RST_B), .MODULE_SELECT_N(sel_n), .MODULE_SELECT_DRIVEN(sel_drv),
        .MODULE_RESET_N(rst_n), .LOW_POWER_REQUEST(lp), .FAULT_INTERRUPT_N_OUT(int_out),
        .FAULT_INTERRUPT_N_OE_N(int_oe_n), .PRESENCE_N(presence_n), .SCL_IN(scl),
        .SDA_IN(sda), .SDA_OUT(sda_out), .SDA_OE_N(sda_oe_n), .BUS_SCL(bus_scl),
        .BUS_SDA(bus_sda), .ENGINE_SDA_LOW(ENGINE_SDA_LOW), .INT_CLEAR(INT_CLEAR),
        .FAULT_EVENT(FAULT_EVENT), .INT_FLAGS(INT_FLAGS), .STATUS_VALID(STATUS_VALID),
        .SETTINGS_RESET(SETTINGS_RESET), .LOW_POWER_MODE(LOW_POWER_MODE));

    // verdict and end of run, the single exit point
    task automatic report_and_stop();
        $display("checked %0d miscompares %0d", checked, miscompares);
        if (miscompares == 0 && checked > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask : report_and_stop

    // bounded wait: 0 watches status valid, 1 watches settings reset
    task automatic wait_for(input int which, input logic want);
        int n;
        n = 0;
        while (((which == 0) ? STATUS_VALID : SETTINGS_RESET) !== want && n < 40) begin
            @(negedge CLK);
            n++;
        end
        if (n >= 40) begin
            miscompares++;
            $display("Error wait %0d expected %0h seen timeout", which, want);
            report_and_stop();
        end
    endtask : wait_for

    // flag model step: set wins over clear, taken at each edge
    task automatic model_step();
        mflags = (mflags & ~int'(INT_CLEAR)) | (int'(FAULT_EVENT) << 1);
    endtask : model_step

    // main sequence
    initial begin
        void'($urandom(81));
        repeat (12) @(posedge CLK);
        RST_B <= 1'b1;
        // power-up behaves like hot insertion: done without a pulse
        wait_for(0, 1'b1);
        @(negedge CLK);
        mflags = 1;
        `CHK("done flag", 1'b1, INT_FLAGS[0])
        `CHK("int line", 1'b0, int_line)
        `CHK("int data", 1'b0, int_out)
        `CHK("presence", 1'b0, presence_n)
        @(negedge CLK);
        `CHK("trusted", 1'b1, trusted)
        // bus gate: selected, deselected, undriven
        for (int k = 0; k < 3; k++) begin
            act = (k == 0);
            host.set_pins(k == 1, k != 2, 1'b0, 1'b0, 1'b1);
            ENGINE_SDA_LOW <= 1'b1;
            repeat (4) @(negedge CLK);
            `CHK("bus scl", ~act, bus_scl)
            `CHK("bus sda", ~act, bus_sda)
            `CHK("sda oe", ~act, sda_oe_n)
            `CHK("sda data", 1'b0, sda_out)
            host.set_pins(k == 1, k != 2, 1'b0, 1'b1, 1'b0);
            ENGINE_SDA_LOW <= 1'b0;
            repeat (4) @(negedge CLK);
            `CHK("bus scl idle", 1'b1, bus_scl)
        end
        // low-power pin follows random levels
        for (int k = 0; k < 6; k++) begin
            act = 1'($urandom);
            host.set_pins(1'b0, 1'b1, act, 1'b1, 1'b0);
            repeat (4) @(negedge CLK);
            `CHK("low power", act, LOW_POWER_MODE)
        end
        // random fault events and clears, checked every cycle
        for (int k = 0; k < 40; k++) begin
            @(posedge CLK);
            model_step();
            FAULT_EVENT <= NS'($urandom & $urandom);
            INT_CLEAR   <= (NS + 1)'($urandom);
            @(negedge CLK);
            `CHK("flags", (NS + 1)'(mflags), INT_FLAGS)
            `CHK("int line", (mflags == 0), int_line)
        end
        @(posedge CLK);
        model_step();
        FAULT_EVENT <= NS'(1);
        INT_CLEAR   <= '1;
        @(posedge CLK);
        model_step();
        FAULT_EVENT <= '0;
        INT_CLEAR   <= '0;
        @(negedge CLK);
        `CHK("one fault", (NS + 1)'(mflags), INT_FLAGS)
        // a pulse of exactly the least width is not longer, so ignored
        host.pulse_reset(MINC);
        repeat (6) @(negedge CLK);
        `CHK("short reset", 1'b0, SETTINGS_RESET)
        `CHK("kept flags", (NS + 1)'(mflags), INT_FLAGS)
        `CHK("kept valid", 1'b1, STATUS_VALID)
        // one cycle over the least width resets settings, then done follows
        fork
            host.pulse_reset(MINC + 1);
            begin
                wait_for(1, 1'b1);
                `CHK("flags in reset", '0, INT_FLAGS)
                `CHK("valid in reset", 1'b0, STATUS_VALID)
                `CHK("trusted in reset", 1'b0, trusted)
            end
        join
        wait_for(1, 1'b0);
        wait_for(0, 1'b1);
        @(negedge CLK);
        `CHK("done after reset", (NS + 1)'(1), INT_FLAGS)
        `CHK("int after reset", 1'b0, int_line)
        @(negedge CLK);
        `CHK("trusted after reset", 1'b1, trusted)
        report_and_stop();
    end
endmodule : module_sideband_control_tb

// ### rtl/msc_pkg.sv
// ---------------------------------------------------------------
// sideband control constants
// ---------------------------------------------------------------
package msc_pkg;

    // ---------------------------------------------------------------
    // timing
    // ---------------------------------------------------------------
    localparam int CLK_PERIOD_NS = 100;                      // 10 MHz
    localparam int RESET_MIN_NS  = 1000;                     // least reset pulse, plain default
    localparam int INIT_NS       = 2000;                     // settle time before reset complete
    // least times round up to whole cycles
    localparam int RESET_MIN_CYC = (RESET_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int INIT_CYC      = (INIT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    // ---------------------------------------------------------------
    // widths and reset values
    // ---------------------------------------------------------------
    localparam int         NUM_FAULT_SRC  = 4;               // fault sources beside reset done
    localparam int         CNT_W          = 16;
    localparam int         SYNC_W         = 6;
    localparam int         FLAG_DONE      = 0;               // reset-complete flag position
    // bits: driven, select_n, reset_n, low_power, scl, sda
    localparam logic [5:0] SYNC_RESET_VAL = 6'h1F;

    // ---------------------------------------------------------------
    // control states
    // ---------------------------------------------------------------
    typedef enum logic [1:0] {
        ST_INIT  = 2'b00,                                    // settling after reset
        ST_RUN   = 2'b01,                                    // normal operation
        ST_HELD  = 2'b10,                                    // reset pin low, timing it
        ST_RESET = 2'b11                                     // reset accepted
    } msc_state_e;

endpackage : msc_pkg

// ### rtl/msc_sideband.sv
`timescale 1ns/1ns
// ---------------------------------------------------------------
// module sideband control
// ---------------------------------------------------------------
// How it works
// - the two-wire bus reaches the management engine only while select is held low.
// - with select high the bus is held idle inward and the data line is released.
// - a select pin the host does not drive reads as high, so the module is deselected.
// - a reset pin low for longer than the least pulse width resets all user settings.
// - the end of reset sets the reset-complete flag, which pulls the interrupt low.
// - power-up or hot insertion also ends in a reset-complete flag with no pulse.
// - the interrupt pin is only pulled low or released, never driven high.
// - the presence pin is tied low inside the module.
// - a high low-power pin puts the module in low-power state.
module msc_sideband #(
    parameter int RESET_MIN_CYC = msc_pkg::RESET_MIN_CYC,
    parameter int INIT_CYC      = msc_pkg::INIT_CYC,
    parameter int NSRC          = msc_pkg::NUM_FAULT_SRC
) (
    // clock and reset
    input  wire logic          CLK,
    input  wire logic          RST_B,
    // host sideband pins
    input  wire logic          MODULE_SELECT_N,
    input  wire logic          MODULE_SELECT_DRIVEN,
    input  wire logic          MODULE_RESET_N,
    input  wire logic          LOW_POWER_REQUEST,
    output logic               FAULT_INTERRUPT_N_OUT,
    output logic               FAULT_INTERRUPT_N_OE_N,
    output logic               PRESENCE_N,
    // two-wire bus pins
    input  wire logic          SCL_IN,
    input  wire logic          SDA_IN,
    output logic               SDA_OUT,
    output logic               SDA_OE_N,
    // management engine side
    output logic               BUS_SCL,
    output logic               BUS_SDA,
    input  wire logic          ENGINE_SDA_LOW,
    input  wire logic [NSRC:0] INT_CLEAR,
    input  wire logic [NSRC:1] FAULT_EVENT,
    output logic      [NSRC:0] INT_FLAGS,
    output logic               STATUS_VALID,
    output logic               SETTINGS_RESET,
    output logic               LOW_POWER_MODE
);

    // ---------------------------------------------------------------
    // state
    // ---------------------------------------------------------------
    typedef struct packed {
        msc_pkg::msc_state_e         state;
        logic [msc_pkg::CNT_W-1:0]   cnt;
        logic [NSRC:0]               flags;
        logic                        bus_scl;
        logic                        bus_sda;
        logic                        sda_oe_n;
        logic                        settings_reset;
        logic                        status_valid;
        logic                        low_power;
    } msc_regs_s;

    localparam logic [msc_pkg::CNT_W-1:0] MIN_CNT  = msc_pkg::CNT_W'(RESET_MIN_CYC);
    localparam logic [msc_pkg::CNT_W-1:0] INIT_END = msc_pkg::CNT_W'(INIT_CYC - 1);

    msc_regs_s                    r;
    msc_regs_s                    next_r;
    logic [msc_pkg::SYNC_W-1:0]   pins_s;
    logic                         driven_s;
    logic                         sel_n_s;
    logic                         rst_n_s;
    logic                         lp_s;
    logic                         scl_s;
    logic                         sda_s;
    logic                         sel_eff_n;
    logic                         bus_active;

    // ---------------------------------------------------------------
    // pin synchronisers
    // ---------------------------------------------------------------
    msc_sync #(
        .WIDTH     (msc_pkg::SYNC_W),
        .RESET_VAL (msc_pkg::SYNC_RESET_VAL)
    ) u_sync (
        .CLK      (CLK),
        .RST_B    (RST_B),
        .ASYNC_IN ({MODULE_SELECT_DRIVEN, MODULE_SELECT_N, MODULE_RESET_N,
                    LOW_POWER_REQUEST, SCL_IN, SDA_IN}),
        .SYNC_OUT (pins_s)
    );

    assign {driven_s, sel_n_s, rst_n_s, lp_s, scl_s, sda_s} = pins_s;

    // ---------------------------------------------------------------
    // select gating
    // ---------------------------------------------------------------
    // undriven select behaves as the internal pull-up
    assign sel_eff_n  = driven_s ? sel_n_s : 1'b1;
    // bus also shut out while a reset runs, status is not valid then
    assign bus_active = !sel_eff_n && (r.state == msc_pkg::ST_RUN);

    // ---------------------------------------------------------------
    // next-state logic
    // ---------------------------------------------------------------
    always_comb begin
        next_r = r;
        // sticky flags: an event in the clear cycle survives
        next_r.flags = (r.flags & ~INT_CLEAR) | {FAULT_EVENT, 1'b0};
        // deselected: idle lines inward, data line released
        next_r.bus_scl   = bus_active ? scl_s : 1'b1;
        next_r.bus_sda   = bus_active ? sda_s : 1'b1;
        next_r.sda_oe_n  = !(bus_active && ENGINE_SDA_LOW);
        next_r.low_power = lp_s;
        case (r.state)
            msc_pkg::ST_INIT: begin
                next_r.cnt = r.cnt + 1'b1;
                if (r.cnt >= INIT_END) begin
                    next_r.state                    = msc_pkg::ST_RUN;
                    next_r.cnt                      = '0;
                    next_r.status_valid             = 1'b1;
                    next_r.flags[msc_pkg::FLAG_DONE] = 1'b1;
                end
            end
            msc_pkg::ST_RUN: begin
                if (!rst_n_s) begin
                    next_r.state = msc_pkg::ST_HELD;
                    next_r.cnt   = msc_pkg::CNT_W'(1);
                end
            end
            msc_pkg::ST_HELD: begin
                // a pulse no longer than the least width is a glitch
                if (rst_n_s) begin
                    next_r.state = msc_pkg::ST_RUN;
                    next_r.cnt   = '0;
                end else if (r.cnt >= MIN_CNT) begin
                    next_r.state          = msc_pkg::ST_RESET;
                    next_r.cnt            = '0;
                    next_r.settings_reset = 1'b1;
                    next_r.status_valid   = 1'b0;
                    next_r.flags          = '0;
                end else begin
                    next_r.cnt = r.cnt + 1'b1;
                end
            end
            msc_pkg::ST_RESET: begin
                // defaults held until the host lets go
                next_r.flags = '0;
                if (rst_n_s) begin
                    next_r.state          = msc_pkg::ST_INIT;
                    next_r.settings_reset = 1'b0;
                end
            end
            default: begin
                next_r.state = msc_pkg::ST_INIT;
                next_r.cnt   = '0;
            end
        endcase
    end

    // ---------------------------------------------------------------
    // state register
    // ---------------------------------------------------------------
    // power-up counts as hot insertion: start settling, no pulse needed
    always_ff @(posedge CLK) begin
        if (!RST_B) begin
            r.state          <= msc_pkg::ST_INIT;
            r.cnt            <= '0;
            r.flags          <= '0;
            r.bus_scl        <= 1'b1;
            r.bus_sda        <= 1'b1;
            r.sda_oe_n       <= 1'b1;
            r.settings_reset <= 1'b0;
            r.status_valid   <= 1'b0;
            r.low_power      <= 1'b1;
        end else begin
            r <= next_r;
        end
    end

    // ---------------------------------------------------------------
    // outputs
    // ---------------------------------------------------------------
    assign FAULT_INTERRUPT_N_OUT  = 1'b0;
    assign FAULT_INTERRUPT_N_OE_N = ~|r.flags;
    assign PRESENCE_N             = 1'b0;
    assign SDA_OUT                = 1'b0;
    assign SDA_OE_N               = r.sda_oe_n;
    assign BUS_SCL                = r.bus_scl;
    assign BUS_SDA                = r.bus_sda;
    assign INT_FLAGS              = r.flags;
    assign STATUS_VALID           = r.status_valid;
    assign SETTINGS_RESET         = r.settings_reset;
    assign LOW_POWER_MODE         = r.low_power;

    // ---------------------------------------------------------------
    // assertions
    // ---------------------------------------------------------------
    default clocking cb @(posedge CLK); endclocking
    default disable iff (!RST_B);

    localparam int A_INIT_MAX = INIT_CYC + 4;
    logic [NSRC:1] hit_and_clear;
    assign hit_and_clear = FAULT_EVENT & INT_CLEAR[NSRC:1];

    sequence s_held_long;
        (r.state == msc_pkg::ST_HELD) && !rst_n_s && (r.cnt == MIN_CNT);
    endsequence
    sequence s_init_last;
        (r.state == msc_pkg::ST_INIT) && (r.cnt == INIT_END);
    endsequence

    property p_selected_pass;
        bus_active |=> (BUS_SCL == $past(scl_s)) && (BUS_SDA == $past(sda_s));
    endproperty
    a_selected_pass: assert property (p_selected_pass)
        else $error("selected bus not passed through");

    property p_deselected_idle;
        sel_eff_n |=> BUS_SCL && BUS_SDA && SDA_OE_N;
    endproperty
    a_deselected_idle: assert property (p_deselected_idle)
        else $error("deselected module touched the bus");

    property p_undriven_select;
        !driven_s |=> BUS_SCL && SDA_OE_N;
    endproperty
    a_undriven_select: assert property (p_undriven_select)
        else $error("undriven select did not deselect");

    property p_long_reset;
        s_held_long |=> (r.state == msc_pkg::ST_RESET) && SETTINGS_RESET && (INT_FLAGS == '0);
    endproperty
    a_long_reset: assert property (p_long_reset)
        else $error("long reset pulse not taken");

    property p_status_hidden;
        SETTINGS_RESET |-> !STATUS_VALID;
    endproperty
    a_status_hidden: assert property (p_status_hidden)
        else $error("status valid during reset");

    property p_done_flag;
        s_init_last |=> INT_FLAGS[msc_pkg::FLAG_DONE] && STATUS_VALID && !FAULT_INTERRUPT_N_OE_N;
    endproperty
    a_done_flag: assert property (p_done_flag)
        else $error("reset complete not flagged");

    property p_insertion_done;
        $rose(STATUS_VALID) |-> $past(r.state) == msc_pkg::ST_INIT ##0
            INT_FLAGS[msc_pkg::FLAG_DONE];
    endproperty
    a_insertion_done: assert property (p_insertion_done)
        else $error("status valid without reset complete");

    property p_power_up_done;
        (r.state == msc_pkg::ST_INIT) && (r.cnt == '0) |-> ##[1:A_INIT_MAX]
            INT_FLAGS[msc_pkg::FLAG_DONE];
    endproperty
    a_power_up_done: assert property (p_power_up_done)
        else $error("no reset complete after settling");

    property p_open_drain;
        !FAULT_INTERRUPT_N_OUT && (FAULT_INTERRUPT_N_OE_N == !(|INT_FLAGS));
    endproperty
    a_open_drain: assert property (p_open_drain)
        else $error("interrupt pin drive wrong");

    property p_set_wins;
        (|hit_and_clear) && (r.state == msc_pkg::ST_RUN) |=>
            ((INT_FLAGS[NSRC:1] & $past(hit_and_clear)) == $past(hit_and_clear));
    endproperty
    a_set_wins: assert property (p_set_wins)
        else $error("fault flag lost on clear");

    property p_presence;
        PRESENCE_N == 1'b0;
    endproperty
    a_presence: assert property (p_presence)
        else $error("presence not low");

    // both levels checked, so a stuck low-power state is caught too
    property p_low_power;
        LOW_POWER_MODE == $past(lp_s);
    endproperty
    a_low_power: assert property (p_low_power)
        else $error("low power not followed");

endmodule : msc_sideband

// ### rtl/msc_sync.sv
`timescale 1ns/1ns
// ---------------------------------------------------------------
// two-stage synchroniser for pin inputs
// ---------------------------------------------------------------
module msc_sync #(
    parameter int                WIDTH     = 1,
    parameter logic [WIDTH-1:0]  RESET_VAL = '0
) (
    // clock and reset
    input  wire logic             CLK,
    input  wire logic             RST_B,
    // pins and synchronised copy
    input  wire logic [WIDTH-1:0] ASYNC_IN,
    output logic      [WIDTH-1:0] SYNC_OUT
);

    typedef struct packed {
        logic [WIDTH-1:0] meta;                              // read by stage two only
        logic [WIDTH-1:0] stable;
    } msc_sync_s;

    msc_sync_s r;
    msc_sync_s next_r;

    // shift chain
    always_comb begin
        next_r.meta   = ASYNC_IN;
        next_r.stable = r.meta;
    end

    // reset to the idle pin levels so nothing fires at release
    always_ff @(posedge CLK) begin
        if (!RST_B) begin
            r <= {RESET_VAL, RESET_VAL};
        end else begin
            r <= next_r;
        end
    end

    assign SYNC_OUT = r.stable;

endmodule : msc_sync
